// ===== design/haps_top.sv
// Alert pin and serial slave address selection with an APB register file.
// Assumes hub state and event inputs come from logic on pclk; straps are pins.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - One configuration bit selects general event or suspend-state alert meaning.
// - Function bit 0: alert goes low when an enabled status bit updates.
// - Function bit 1: alert low unless hub configured and active.
// - Device answers on one of four slave addresses chosen by two straps.
// - Straps captured during hub init stage; captured copy used afterwards.
// - Upper strap picks base address register A or B.
// - Lower strap sets the slave address least significant bit.
module haps_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [haps_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [haps_pkg::NUM_EVT-1:0] hub_event,
    input wire logic hub_configured,
    input wire logic hub_suspended,
    input wire logic hub_init_stage,
    input wire logic [haps_pkg::STRAP_W-1:0] slave_address_straps,
    output logic alert_n_o,
    output logic alert_n_oe,
    output logic [haps_pkg::ADDR_W-1:0] slave_address,
    output logic irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic alert_function_select_q;
    logic [6:0] slave_address_base_a_q;
    logic [6:0] slave_address_base_b_q;
    logic [3:0] int_en_q;
    logic [3:0] irq_mask_q;
    logic [3:0] int_stat;
    logic [3:0] stat_clr;
    logic [1:0] strap_sync;
    logic [1:0] strap_q;
    logic [6:0] slave_address_d;
    logic [6:0] slave_address_q;
    logic alert_oe_d;
    logic alert_oe_q;
    logic alert_out_q;
    logic irq_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_d;
    logic [31:0] prdata_q;
    logic mapped;
    logic setup;
    logic access;
    logic wr_en;
    logic rd_en;
    haps_pkg::haps_mode_t mode;

    assign setup = psel && !penable;
    assign access = psel && penable && pready_q;
    assign wr_en = access && pwrite && mapped;
    assign rd_en = access && !pwrite && mapped;

    // ------------------------------------------------------------
    // Strap synchroniser and status latches
    // ------------------------------------------------------------
    haps_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(slave_address_straps),
        .sync_out(strap_sync)
    );

    haps_evt_latch u_evt (
        .pclk(pclk),
        .presetn(presetn),
        .set_i(hub_event),
        .clr_i(stat_clr),
        .stat_o(int_stat)
    );

    // ------------------------------------------------------------
    // APB address decode
    // ------------------------------------------------------------
    always_comb begin
        case (paddr)
            haps_pkg::OFS_CTRL,
            haps_pkg::OFS_BASE_A,
            haps_pkg::OFS_BASE_B,
            haps_pkg::OFS_INT_STAT,
            haps_pkg::OFS_INT_EN,
            haps_pkg::OFS_IRQ_MASK,
            haps_pkg::OFS_STATE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Read mux, sampled in the setup cycle
    always_comb begin
        prdata_d = 32'h0000_0000;
        case (paddr)
            haps_pkg::OFS_CTRL: begin
                prdata_d[haps_pkg::CTRL_FSEL_BIT] = alert_function_select_q;
            end
            haps_pkg::OFS_BASE_A: begin
                prdata_d[6:0] = slave_address_base_a_q;
            end
            haps_pkg::OFS_BASE_B: begin
                prdata_d[6:0] = slave_address_base_b_q;
            end
            haps_pkg::OFS_INT_STAT: begin
                prdata_d[3:0] = int_stat;
            end
            haps_pkg::OFS_INT_EN: begin
                prdata_d[3:0] = int_en_q;
            end
            haps_pkg::OFS_IRQ_MASK: begin
                prdata_d[3:0] = irq_mask_q;
            end
            haps_pkg::OFS_STATE: begin
                prdata_d[haps_pkg::ST_STRAP_LSB +: 2] = strap_q;
                prdata_d[haps_pkg::ST_ADDR_LSB +: 7] = slave_address_q;
                prdata_d[haps_pkg::ST_CFG_BIT] = hub_configured;
                prdata_d[haps_pkg::ST_SUSP_BIT] = hub_suspended;
                prdata_d[haps_pkg::ST_INIT_BIT] = hub_init_stage;
                prdata_d[haps_pkg::ST_ALERT_BIT] = alert_oe_q;
            end
            default: begin
                prdata_d = 32'h0000_0000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // APB handshake: one wait-free access cycle
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !mapped;
            if (setup) begin
                prdata_q <= pwrite ? 32'h0000_0000 : prdata_d;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alert_function_select_q <= haps_pkg::RST_FSEL;
        end else if (wr_en && paddr == haps_pkg::OFS_CTRL) begin
            alert_function_select_q <= pwdata[haps_pkg::CTRL_FSEL_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slave_address_base_a_q <= haps_pkg::RST_BASE_A;
            slave_address_base_b_q <= haps_pkg::RST_BASE_B;
        end else if (wr_en) begin
            if (paddr == haps_pkg::OFS_BASE_A) begin
                slave_address_base_a_q <= pwdata[6:0];
            end
            if (paddr == haps_pkg::OFS_BASE_B) begin
                slave_address_base_b_q <= pwdata[6:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_en_q <= haps_pkg::RST_INT_EN;
            irq_mask_q <= haps_pkg::RST_IRQ_MASK;
        end else if (wr_en) begin
            if (paddr == haps_pkg::OFS_INT_EN) begin
                int_en_q <= pwdata[3:0];
            end
            if (paddr == haps_pkg::OFS_IRQ_MASK) begin
                irq_mask_q <= pwdata[3:0];
            end
        end
    end

    // Write-one-to-clear, or clear-all on read; a same-cycle event wins
    always_comb begin
        stat_clr = 4'h0;
        if (access && mapped && paddr == haps_pkg::OFS_INT_STAT) begin
            stat_clr = pwrite ? pwdata[3:0] : 4'hf;
        end
    end

    // ------------------------------------------------------------
    // Strap capture and slave address
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_q <= haps_pkg::RST_STRAP;
        end else if (hub_init_stage) begin
            strap_q <= strap_sync;
        end
    end

    always_comb begin
        slave_address_d = strap_q[1] ? slave_address_base_b_q : slave_address_base_a_q;
        slave_address_d[0] = strap_q[0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slave_address_q <= {haps_pkg::RST_BASE_A[6:1], 1'b0};
        end else begin
            slave_address_q <= slave_address_d;
        end
    end

    // ------------------------------------------------------------
    // Alert pin
    // ------------------------------------------------------------
    always_comb begin
        mode = alert_function_select_q ? haps_pkg::HAPS_MODE_SUSPEND
                                       : haps_pkg::HAPS_MODE_GENERAL;
        case (mode)
            haps_pkg::HAPS_MODE_GENERAL: begin
                alert_oe_d = |(int_stat & int_en_q);
            end
            haps_pkg::HAPS_MODE_SUSPEND: begin
                alert_oe_d = !(hub_configured && !hub_suspended);
            end
            default: begin
                alert_oe_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alert_oe_q <= 1'b0;
            alert_out_q <= 1'b0;
        end else begin
            alert_oe_q <= alert_oe_d;
            alert_out_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(int_stat & irq_mask_q);
        end
    end

    assign alert_n_o = alert_out_q;
    assign alert_n_oe = alert_oe_q;
    assign slave_address = slave_address_q;
    assign irq = irq_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign prdata = prdata_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_pending;
        !alert_function_select_q && (|(int_stat & int_en_q));
    endsequence

    sequence s_no_clear;
        stat_clr == 4'h0 && hub_event == 4'h0;
    endsequence

    // Pending with no clear, then one more cycle in general mode with unchanged enables
    sequence s_held;
        (s_pending and s_no_clear)
        ##1 (!alert_function_select_q && $stable(int_en_q));
    endsequence

    sequence s_addr_inputs_stable;
        $stable(slave_address_base_a_q) && $stable(slave_address_base_b_q)
        && $stable(strap_q);
    endsequence

    a_gen_alert_low: assert property (s_pending |=> alert_oe_q)
        else $error("alert not driven low on pending enabled status");

    a_gen_alert_hold: assert property (s_held |-> alert_oe_q[*2])
        else $error("alert released without a status clear");

    a_idle_released: assert property (
        (!alert_function_select_q && (int_stat & int_en_q) == 4'h0)
        |=> !alert_oe_q)
        else $error("alert low with no enabled status pending");

    a_susp_alert_low: assert property (
        (alert_function_select_q && (!hub_configured || hub_suspended))
        |=> alert_oe_q)
        else $error("suspend mode alert not low while unconfigured or suspended");

    a_susp_alert_high: assert property (
        (alert_function_select_q && hub_configured && !hub_suspended)
        |=> !alert_oe_q)
        else $error("suspend mode alert low while hub active");

    a_mode_select: assert property (
        ($changed(alert_function_select_q) && hub_configured && !hub_suspended
         && (int_stat & int_en_q) != 4'h0)
        |=> alert_oe_q != alert_function_select_q)
        else $error("alert meaning does not follow function select");

    a_strap_frozen: assert property (
        (!hub_init_stage && !$past(hub_init_stage)) |-> $stable(strap_q))
        else $error("strap copy changed outside init stage");

    a_addr_base_sel: assert property (
        ##1 slave_address_q[6:1] == ($past(strap_q[1]) ? $past(slave_address_base_b_q[6:1])
                                                       : $past(slave_address_base_a_q[6:1])))
        else $error("slave address base not chosen by upper strap");

    a_addr_lsb: assert property (##1 slave_address_q[0] == $past(strap_q[0]))
        else $error("slave address lsb does not follow lower strap");

    a_addr_four: assert property (
        s_addr_inputs_stable ##1 s_addr_inputs_stable
        |-> slave_address_q == slave_address_d)
        else $error("slave address not settled to strap selection");

    a_apb_ready: assert property (setup |=> pready_q ##1 !pready_q)
        else $error("apb ready not a single access cycle");

endmodule

`default_nettype wire

// ===== design/haps_pkg.sv
// Constants for the hub alert pin and slave address select block.
// Assumes a 20 MHz APB clock and hub-core inputs on that same clock.
package haps_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned NUM_EVT = 4;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned STRAP_W = 2;
    localparam int unsigned PADDR_W = 8;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BASE_A = 8'h04;
    localparam logic [7:0] OFS_BASE_B = 8'h08;
    localparam logic [7:0] OFS_INT_STAT = 8'h0c;
    localparam logic [7:0] OFS_INT_EN = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_STATE = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CTRL_FSEL_BIT = 0;
    localparam int unsigned ST_STRAP_LSB = 0;
    localparam int unsigned ST_ADDR_LSB = 8;
    localparam int unsigned ST_CFG_BIT = 16;
    localparam int unsigned ST_SUSP_BIT = 17;
    localparam int unsigned ST_INIT_BIT = 18;
    localparam int unsigned ST_ALERT_BIT = 19;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_FSEL = 1'b0;
    localparam logic [6:0] RST_BASE_A = 7'h10;
    localparam logic [6:0] RST_BASE_B = 7'h20;
    localparam logic [3:0] RST_INT_EN = 4'h0;
    localparam logic [3:0] RST_IRQ_MASK = 4'h0;
    localparam logic [1:0] RST_STRAP = 2'h0;

    // ------------------------------------------------------------
    // Alert mode encoding
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HAPS_MODE_GENERAL = 2'b01,
        HAPS_MODE_SUSPEND = 2'b10
    } haps_mode_t;

endpackage

// ===== design/haps_sync.sv
// Two-flop synchroniser for the address strap pins.
// Assumes the pins are quasi-static and asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none

module haps_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [haps_pkg::STRAP_W-1:0] async_in,
    output logic [haps_pkg::STRAP_W-1:0] sync_out
);

    // ------------------------------------------------------------
    // Per-bit double flop
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < haps_pkg::STRAP_W; i++) begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= async_in[i];
                    sync_q <= meta_q;
                end
            end
            assign sync_out[i] = sync_q;
        end
    endgenerate

endmodule

`default_nettype wire

// ===== design/haps_evt_latch.sv
// Sticky event status bits; a set in the same cycle as a clear wins.
// Assumes set and clear are pulses on pclk.
`timescale 1ns/1ps
`default_nettype none

module haps_evt_latch (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [haps_pkg::NUM_EVT-1:0] set_i,
    input wire logic [haps_pkg::NUM_EVT-1:0] clr_i,
    output logic [haps_pkg::NUM_EVT-1:0] stat_o
);

    // ------------------------------------------------------------
    // Per-event flag
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < haps_pkg::NUM_EVT; i++) begin : g_evt
            logic flag_q;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag_q <= 1'b0;
                end else if (set_i[i]) begin
                    flag_q <= 1'b1;
                end else if (clr_i[i]) begin
                    flag_q <= 1'b0;
                end
            end
            assign stat_o[i] = flag_q;
        end
    endgenerate

endmodule

`default_nettype wire

// ===== dv/haps_host_model.sv
// Host side of the alert pin: open-drain wire with pull-up, plus current choice.
// Assumes alert_n_oe high means the device pulls the pin to alert_n_o.
`timescale 1ns/1ps
`default_nettype none

module haps_host_model (
    input wire logic alert_n_o,
    input wire logic alert_n_oe,
    output logic alert_pin,
    output logic full_current
);
    // Pull-up wins whenever the device releases the pin
    assign alert_pin = alert_n_oe ? alert_n_o : 1'b1;
    // Configured current only while the pin is released high
    assign full_current = alert_pin;
endmodule

`default_nettype wire

// ===== dv/tb.sv
// Self-checking bench for the alert pin and slave address block.
// Assumes APB at 20 MHz and hub inputs driven on the same clock.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] hub_event = 4'h0;
    logic hub_configured = 1'b0;
    logic hub_suspended = 1'b0;
    logic hub_init_stage = 1'b0;
    logic [1:0] slave_address_straps = 2'h0;
    logic alert_n_o;
    logic alert_n_oe;
    logic [6:0] slave_address;
    logic irq;
    logic alert_pin;
    logic full_current;
    int n_errors = 0;
    int total_checks = 0;
    logic [31:0] rv;
    logic ev;

    always #25 pclk = ~pclk;

    haps_top haps_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hub_event(hub_event),
        .hub_configured(hub_configured), .hub_suspended(hub_suspended),
        .hub_init_stage(hub_init_stage), .slave_address_straps(slave_address_straps),
        .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe),
        .slave_address(slave_address), .irq(irq)
    );

    haps_host_model haps_host_model_inst (
        .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe),
        .alert_pin(alert_pin), .full_current(full_current)
    );

    // ------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Outputs are read at the edge, before the design's flops move
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        if (pready !== 1'b1) begin
            n_errors++;
            $display("[ERR] apb_ready expected 1 seen %b", pready);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic pulse(input logic [3:0] e);
        @(posedge pclk);
        hub_event <= e;
        @(posedge pclk);
        hub_event <= 4'h0;
        idle(3);
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        #(50 * 5000);
        n_errors++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        idle(1);
        `CHK("pin_after_reset", 1'b1, alert_pin)
        `CHK("addr_after_reset", 7'h10, slave_address)
        apb(1'b0, haps_pkg::OFS_BASE_A, 32'h0, rv, ev);
        `CHK("base_a_reset", 32'h10, rv)
        apb(1'b0, haps_pkg::OFS_BASE_B, 32'h0, rv, ev);
        `CHK("base_b_reset", 32'h20, rv)
        apb(1'b0, 8'h1c, 32'h0, rv, ev);
        `CHK("unmapped_err", 1'b1, ev)
        `CHK("unmapped_data", 32'h0, rv)

        // General event mode
        wr(haps_pkg::OFS_INT_EN, 32'h1);
        wr(haps_pkg::OFS_IRQ_MASK, 32'h2);
        pulse(4'h2);
        `CHK("pin_disabled_evt", 1'b1, alert_pin)
        `CHK("irq_masked_in", 1'b1, irq)
        apb(1'b0, haps_pkg::OFS_INT_STAT, 32'h0, rv, ev);
        `CHK("stat_read", 32'h2, rv)
        idle(2);
        `CHK("irq_cleared", 1'b0, irq)
        pulse(4'h1);
        `CHK("pin_evt_low", 1'b0, alert_pin)
        `CHK("irq_unmasked_bit", 1'b0, irq)
        idle(20);
        `CHK("pin_held_low", 1'b0, alert_pin)
        wr(haps_pkg::OFS_INT_STAT, 32'h1);
        idle(2);
        `CHK("pin_released", 1'b1, alert_pin)

        // Suspend-state mode
        wr(haps_pkg::OFS_CTRL, 32'h1);
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            hub_configured <= i[1];
            hub_suspended <= i[0];
            idle(3);
            `CHK("susp_pin", (i == 2) ? 1'b1 : 1'b0, alert_pin)
            `CHK("susp_current", (i == 2) ? 1'b1 : 1'b0, full_current)
        end
        wr(haps_pkg::OFS_CTRL, 32'h0);
        idle(2);
        `CHK("mode_back", 1'b1, alert_pin)
        @(posedge pclk);
        hub_suspended <= 1'b0;
        wr(haps_pkg::OFS_CTRL, 32'h1);
        pulse(4'h1);
        `CHK("susp_evt_ignored", 1'b1, alert_pin)
        wr(haps_pkg::OFS_CTRL, 32'h0);
        idle(2);
        `CHK("mode_evt_low", 1'b0, alert_pin)
        wr(haps_pkg::OFS_INT_STAT, 32'h1);
        idle(2);
        `CHK("evt_cleared", 1'b1, alert_pin)

        // Address straps
        wr(haps_pkg::OFS_BASE_A, 32'h34);
        wr(haps_pkg::OFS_BASE_B, 32'h5b);
        for (int s = 0; s < 4; s++) begin
            @(posedge pclk);
            slave_address_straps <= s[1:0];
            hub_init_stage <= 1'b1;
            idle(6);
            @(posedge pclk);
            hub_init_stage <= 1'b0;
            slave_address_straps <= ~s[1:0];
            idle(6);
            `CHK("slave_addr", ((s[1] ? 7'h5b : 7'h34) & 7'h7e) | {6'h0, s[0]},
                 slave_address)
        end
        wrap_up();
    end
endmodule

`default_nettype wire
